// ===== mcg_params.svh
// Purpose: offsets, field positions, reset values for the mac config block
// Assumes: byte addresses relative to the block base
// Notes:   alias codes are matched against address bits 3:2 under each base offset
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH
`define MCG_OFS_ALIGN_ERR   16'h9160
`define MCG_OFS_CFG_ONE     16'h9200
`define MCG_OFS_CFG_TWO     16'h9210
`define MCG_OFS_B2B_GAP     16'h9220
`define MCG_OFS_NB2B_GAP    16'h9230
`define MCG_OFS_COLL_RETRY  16'h9240
`define MCG_OFS_MAX_FRAME   16'h9250
`define MCG_ALIAS_CLEAR     2'h1
`define MCG_ALIAS_SET       2'h2
`define MCG_ALIAS_TOGGLE    2'h3
`define MCG_RST_ALIGN_ERR   32'h0000_0000
`define MCG_RST_CFG_ONE     32'h0000_800D
`define MCG_RST_CFG_TWO     32'h0000_4082
`define MCG_RST_B2B_GAP     32'h0000_0012
`define MCG_RST_NB2B_GAP    32'h0000_0C12
`define MCG_RST_COLL_RETRY  32'h0000_370F
`define MCG_RST_MAX_FRAME   32'h0000_05EE
`define MCG_MASK_ALIGN_ERR  32'h0000_FFFF
`define MCG_MASK_CFG_ONE    32'h0000_CF1F
`define MCG_MASK_CFG_TWO    32'h0000_73FF
`define MCG_MASK_B2B_GAP    32'h0000_007F
`define MCG_MASK_NB2B_GAP   32'h0000_7F7F
`define MCG_MASK_COLL_RETRY 32'h0000_3F0F
`define MCG_MASK_MAX_FRAME  32'h0000_FFFF
`define MCG_GAP_W           7
`define MCG_DUPLEX_BIT      0
`endif

// ===== mcg_pkg.sv
// Purpose: types for the mac config block
// Assumes: included params header
// Notes:   none
`default_nettype none
package mcg_pkg;
   typedef enum logic [2:0] {
      MCG_IDLE = 3'b001,
      MCG_GAP  = 3'b010,
      MCG_SEND = 3'b100
   } mcg_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [1:0]  size;
   } mcg_req_t;
endpackage : mcg_pkg
`default_nettype wire

// ===== mcg_regs.sv
// Purpose: ahb-lite register slice of an ethernet mac with tx gap timer
// Assumes: single whole-word or halfword transfers, zero wait states
// Notes:   gap timer counts one nibble per nibble_tick pulse
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "mcg_params.svh"

// Summary of operation
// R01 - seven-bit back-to-back gap field spaces transmitted packets in nibble times
// R02 - full duplex software writes wanted spacing minus three
// R03 - half duplex software writes wanted spacing minus six
// R04 - full duplex recommended gap value is 21
// R05 - half duplex recommended gap value is 18
// R06 - sixteen and thirty-two bit accesses work; byte accesses ignored
// R07 - clear, set, invert aliases sit at base plus 4, 8, 12
// R08 - gap register bits 31 to 7 read zero, ignore writes
// R09 - alias writes clear, set or toggle bits written as one
module mcg_regs
   import mcg_pkg::*;
(
   // bus
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // mac events
   input  wire logic        align_err_evt,
   input  wire logic        nibble_tick,
   input  wire logic        tx_frame_end,
   input  wire logic        tx_frame_req,
   // mac controls
   output logic             tx_frame_ok,
   output logic             duplex_select,
   output logic [31:0]      cfg_one,
   output logic [31:0]      cfg_two,
   output logic [31:0]      gap_nb2b,
   output logic [31:0]      coll_retry,
   output logic [15:0]      frame_length_limit
);
   localparam int NREG = 7;

   logic [31:0] regs_ff [NREG];
   mcg_req_t    req_ff;
   logic [31:0] hrdata_ff;
   mcg_state_t  state_ff;
   logic [7:0]  gap_cnt_ff;
   logic [31:0] wr_val;
   logic        acc_ok;

   function automatic logic [3:0] reg_index(input logic [15:0] a);
      logic [15:0] b;
      b = {a[15:4], 4'h0};
      case (b)
         `MCG_OFS_ALIGN_ERR:  reg_index = 4'h0;
         `MCG_OFS_CFG_ONE:    reg_index = 4'h1;
         `MCG_OFS_CFG_TWO:    reg_index = 4'h2;
         `MCG_OFS_B2B_GAP:    reg_index = 4'h3;
         `MCG_OFS_NB2B_GAP:   reg_index = 4'h4;
         `MCG_OFS_COLL_RETRY: reg_index = 4'h5;
         `MCG_OFS_MAX_FRAME:  reg_index = 4'h6;
         default:             reg_index = 4'hF;
      endcase
   endfunction : reg_index

   function automatic logic [31:0] reg_mask(input logic [3:0] i);
      case (i)
         4'h0:    reg_mask = `MCG_MASK_ALIGN_ERR;
         4'h1:    reg_mask = `MCG_MASK_CFG_ONE;
         4'h2:    reg_mask = `MCG_MASK_CFG_TWO;
         4'h3:    reg_mask = `MCG_MASK_B2B_GAP;
         4'h4:    reg_mask = `MCG_MASK_NB2B_GAP;
         4'h5:    reg_mask = `MCG_MASK_COLL_RETRY;
         4'h6:    reg_mask = `MCG_MASK_MAX_FRAME;
         default: reg_mask = 32'h0000_0000;
      endcase
   endfunction : reg_mask

   function automatic logic [31:0] reg_reset(input int i);
      case (i)
         1:       reg_reset = `MCG_RST_CFG_ONE;
         2:       reg_reset = `MCG_RST_CFG_TWO;
         3:       reg_reset = `MCG_RST_B2B_GAP;
         4:       reg_reset = `MCG_RST_NB2B_GAP;
         5:       reg_reset = `MCG_RST_COLL_RETRY;
         6:       reg_reset = `MCG_RST_MAX_FRAME;
         default: reg_reset = `MCG_RST_ALIGN_ERR;
      endcase
   endfunction : reg_reset

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_ff <= '0;
      end else if (hready) begin
         req_ff.valid <= hsel & htrans[1];
         req_ff.write <= hwrite;
         req_ff.addr  <= haddr[15:0];
         req_ff.size  <= hsize[1:0];
      end
   end

   // R06 byte access dropped
   assign acc_ok = req_ff.valid && (req_ff.size != 2'h0);

   // halfword writes land in the lane picked by addr[1]; other lane held zero
   always_comb begin
      wr_val = hwdata;
      if (req_ff.size == 2'h1) begin
         wr_val = req_ff.addr[1] ? {hwdata[31:16], 16'h0000} : {16'h0000, hwdata[15:0]};
      end
   end

   // R07 R09 alias decode and update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NREG; i++) begin
            regs_ff[i] <= reg_reset(i);
         end
      end else begin
         if (align_err_evt) begin
            regs_ff[0] <= (regs_ff[0] + 32'h1) & `MCG_MASK_ALIGN_ERR;
         end
         for (int i = 0; i < NREG; i++) begin
            if (acc_ok && req_ff.write && reg_index(req_ff.addr) == 4'(i)) begin
               // R08 mask unimplemented bits
               case (req_ff.addr[3:2])
                  `MCG_ALIAS_CLEAR:  regs_ff[i] <= regs_ff[i] & ~(wr_val & reg_mask(4'(i)));
                  `MCG_ALIAS_SET:    regs_ff[i] <= regs_ff[i] | (wr_val & reg_mask(4'(i)));
                  `MCG_ALIAS_TOGGLE: regs_ff[i] <= regs_ff[i] ^ (wr_val & reg_mask(4'(i)));
                  default:           regs_ff[i] <= wr_val & reg_mask(4'(i));
               endcase
            end
         end
      end
   end

   // aliases read back the base value; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite && hsize[1:0] != 2'h0) begin
         hrdata_ff <= 32'h0000_0000;
         for (int i = 0; i < NREG; i++) begin
            if (reg_index(haddr[15:0]) == 4'(i)) begin
               hrdata_ff <= regs_ff[i] & reg_mask(4'(i));
            end
         end
      end
   end

   assign cfg_one            = regs_ff[1];
   assign cfg_two            = regs_ff[2];
   assign gap_nb2b           = regs_ff[4];
   assign coll_retry         = regs_ff[5];
   assign frame_length_limit = regs_ff[6][15:0];
   assign duplex_select      = regs_ff[2][`MCG_DUPLEX_BIT];

   // R01 gap spacing state machine
   // R02 R03 full duplex adds three nibbles, half six
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff   <= MCG_IDLE;
         gap_cnt_ff <= 8'h00;
      end else begin
         case (state_ff)
            MCG_IDLE: begin
               if (tx_frame_end) begin
                  state_ff   <= MCG_GAP;
                  gap_cnt_ff <= {1'b0, regs_ff[3][`MCG_GAP_W-1:0]}
                                + (duplex_select ? 8'h03 : 8'h06);
               end
            end
            MCG_GAP: begin
               if (nibble_tick) begin
                  gap_cnt_ff <= gap_cnt_ff - 8'h01;
                  if (gap_cnt_ff <= 8'h01) begin
                     state_ff <= MCG_SEND;
                  end
               end
            end
            MCG_SEND: begin
               if (tx_frame_end) begin
                  state_ff   <= MCG_GAP;
                  gap_cnt_ff <= {1'b0, regs_ff[3][`MCG_GAP_W-1:0]}
                                + (duplex_select ? 8'h03 : 8'h06);
               end
            end
            default: state_ff <= MCG_IDLE;
         endcase
      end
   end

   // gate only: the next frame may not start while the gap runs
   assign tx_frame_ok = tx_frame_req && (state_ff != MCG_GAP);

   // R08 gap upper bits zero
   AST_GAP_UPPER_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // R08
      regs_ff[3][31:7] == 25'h0) else $error("gap upper bits set");

   // R06 byte write ignored
   AST_BYTE_IGNORED: assert property (@(posedge hclk) disable iff (!hresetn) // R06
      (req_ff.valid && req_ff.write && req_ff.size == 2'h0 && !align_err_evt)
      |=> $stable(regs_ff[3]) && $stable(regs_ff[2]))
      else $error("byte write changed register");

   // R07 set alias on gap register
   AST_SET_ALIAS: assert property (@(posedge hclk) disable iff (!hresetn) // R07
      (acc_ok && req_ff.write && req_ff.addr == (`MCG_OFS_B2B_GAP + 16'h8))
      |=> regs_ff[3] == ($past(regs_ff[3]) | ($past(wr_val) & `MCG_MASK_B2B_GAP)))
      else $error("set alias wrong");

   // R09 invert alias toggles
   AST_INV_ALIAS: assert property (@(posedge hclk) disable iff (!hresetn) // R09
      (acc_ok && req_ff.write && req_ff.addr == (`MCG_OFS_CFG_TWO + 16'hC))
      |=> regs_ff[2] == ($past(regs_ff[2]) ^ ($past(wr_val) & `MCG_MASK_CFG_TWO)))
      else $error("invert alias wrong");

   // R01 frame blocked during gap
   AST_GAP_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn) // R01
      (state_ff == MCG_IDLE && tx_frame_end) |=> (state_ff == MCG_GAP) && !tx_frame_ok)
      else $error("frame allowed inside gap");
endmodule : mcg_regs
`default_nettype wire

// ===== mcg_regs_tb_top.sv
// Purpose: self-checking bench for the mac config register slice
// Assumes: zero-wait ahb-lite slave, registered read data
// Notes:   gap measured in tick pulses until the next frame may start
`timescale 1ns/10ps
`default_nettype none
`include "mcg_params.svh"
module mcg_regs_tb_top;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        align_err_evt, nibble_tick, tx_frame_end, tx_frame_req;
   logic        tx_frame_ok, duplex_select;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd, cfg_one, cfg_two, gap_nb2b, coll_retry;
   logic [15:0] frame_length_limit;
   logic [15:0] ofs [7];
   logic [31:0] rst [7];
   int          n_errors, check_count;
   int          cycles = 0;

   // one slave, so its ready is the bus ready
   assign hready = hreadyout;

   mcg_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .align_err_evt(align_err_evt), .nibble_tick(nibble_tick),
      .tx_frame_end(tx_frame_end), .tx_frame_req(tx_frame_req),
      .tx_frame_ok(tx_frame_ok), .duplex_select(duplex_select), .cfg_one(cfg_one),
      .cfg_two(cfg_two), .gap_nb2b(gap_nb2b), .coll_retry(coll_retry),
      .frame_length_limit(frame_length_limit));

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // address phase held until ready, then data phase held until ready
   task automatic bus(input logic w, input logic [15:0] a, input logic [2:0] sz,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {16'h0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= sz;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      bus(1'b0, a, 3'h2, 32'h0000_0000);
      chk($sformatf("reg %h", a), e, rd);
   endtask : rchk

   // frame end starts the gap; ticks are counted until a request is let through
   task automatic gap(input logic [31:0] e);
      int n;
      n = 0;
      tx_frame_req <= 1'b1;
      tx_frame_end <= 1'b1;
      @(posedge hclk);
      tx_frame_end <= 1'b0;
      @(posedge hclk);
      while (tx_frame_ok !== 1'b1 && n < 200) begin
         nibble_tick <= 1'b1;
         @(posedge hclk);
         nibble_tick <= 1'b0;
         @(posedge hclk);
         n++;
      end
      chk("gap ticks", e, 32'(n));
      tx_frame_req <= 1'b0;
   endtask : gap

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // hang guard, whole run needs well under this
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; align_err_evt = 1'b0; nibble_tick = 1'b0;
      tx_frame_end = 1'b0; tx_frame_req = 1'b0; n_errors = 0; check_count = 0;
      ofs = '{`MCG_OFS_ALIGN_ERR, `MCG_OFS_CFG_ONE, `MCG_OFS_CFG_TWO, `MCG_OFS_B2B_GAP,
              `MCG_OFS_NB2B_GAP, `MCG_OFS_COLL_RETRY, `MCG_OFS_MAX_FRAME};
      rst = '{32'h0000_0000, 32'h0000_800D, 32'h0000_4082, 32'h0000_0012,
              32'h0000_0C12, 32'h0000_370F, 32'h0000_05EE};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 7; i++) begin
         rchk(ofs[i], rst[i]);
      end
      chk("length limit", 32'h0000_05EE, {16'h0000, frame_length_limit});
      chk("cfg one", `MCG_RST_CFG_ONE, cfg_one);
      chk("nb2b gap", `MCG_RST_NB2B_GAP, gap_nb2b);
      chk("coll retry", `MCG_RST_COLL_RETRY, coll_retry);
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
      chk("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
      rchk(16'h9300, 32'h0000_0000);
      bus(1'b1, `MCG_OFS_B2B_GAP, 3'h2, 32'hFFFF_FFFF);
      rchk(`MCG_OFS_B2B_GAP, 32'h0000_007F);
      bus(1'b1, `MCG_OFS_B2B_GAP + 16'h0004, 3'h2, 32'h0000_0055);
      rchk(`MCG_OFS_B2B_GAP, 32'h0000_002A);
      bus(1'b1, `MCG_OFS_B2B_GAP + 16'h0008, 3'h2, 32'h0000_0041);
      rchk(`MCG_OFS_B2B_GAP, 32'h0000_006B);
      bus(1'b1, `MCG_OFS_B2B_GAP + 16'h000C, 3'h2, 32'h0000_000F);
      rchk(`MCG_OFS_B2B_GAP, 32'h0000_0064);
      // byte writes, plain and through an alias, leave state alone
      bus(1'b1, `MCG_OFS_B2B_GAP, 3'h0, 32'h0000_0011);
      bus(1'b1, `MCG_OFS_B2B_GAP + 16'h0008, 3'h0, 32'h0000_0001);
      rchk(`MCG_OFS_B2B_GAP, 32'h0000_0064);
      bus(1'b1, `MCG_OFS_B2B_GAP, 3'h1, 32'h0000_0012);
      rchk(`MCG_OFS_B2B_GAP, 32'h0000_0012);
      gap(32'd24);
      bus(1'b1, `MCG_OFS_CFG_TWO + 16'h0008, 3'h2, 32'h0000_0001);
      @(posedge hclk);
      chk("duplex", 32'h0000_0001, {31'h0, duplex_select});
      bus(1'b1, `MCG_OFS_B2B_GAP, 3'h2, 32'h0000_0015);
      gap(32'd24);
      bus(1'b1, `MCG_OFS_B2B_GAP, 3'h2, 32'h0000_0000);
      gap(32'd3);
      bus(1'b1, `MCG_OFS_CFG_TWO + 16'h0004, 3'h2, 32'h0000_0001);
      gap(32'd6);
      bus(1'b1, `MCG_OFS_B2B_GAP, 3'h2, 32'h0000_0002);
      gap(32'd8);
      // invert alias on cfg_two, then alias read returns base value
      bus(1'b1, `MCG_OFS_CFG_TWO + 16'h000C, 3'h2, 32'h0000_0100);
      rchk(`MCG_OFS_CFG_TWO, 32'h0000_4182);
      chk("cfg two", 32'h0000_4182, cfg_two);
      rchk(`MCG_OFS_CFG_TWO + 16'h000C, 32'h0000_4182);
      align_err_evt <= 1'b1;
      repeat (2) @(posedge hclk);
      align_err_evt <= 1'b0;
      @(posedge hclk);
      rchk(`MCG_OFS_ALIGN_ERR, 32'h0000_0002);
      close_out();
   end
endmodule : mcg_regs_tb_top
`default_nettype wire
